/* hdl/apb_pkg.sv */
// Shared constants and types for the asynchronous-phase protection code
package apb_pkg;
   localparam int APB_INFO_W = 15;
   localparam int APB_CHK_W = 6;
   localparam int APB_SEQ_W = 2;
   localparam int APB_DB_W = 16;
   localparam int APB_POS_RSVD = 10;
   localparam int APB_POS_SEQ = 13;
   localparam int APB_POS_CHK = 15;
   localparam int APB_CNT_W = 4;
   localparam int APB_ENABLE_WORDS = 2;
   localparam int APB_DISABLE_WORDS = 4;
   localparam int APB_NEXUS_W = 4;
   localparam logic [APB_CHK_W-1:0] APB_GEN_TAPS = 6'h25;
   localparam logic [APB_CHK_W-1:0] APB_LFSR_RESET = 6'h00;
   localparam logic [APB_SEQ_W-1:0] APB_SEQ_RESET = 2'h0;
   // Code word positions folded into each check bit
   localparam logic [APB_CHK_W-1:0][APB_INFO_W-1:0] APB_CHK_MASK = {
      15'h5677, 15'h7d4c, 15'h3ea6, 15'h1f53, 15'h59de, 15'h2cef};
   typedef enum logic [1:0] {APB_PH_COMMAND, APB_PH_MESSAGE, APB_PH_STATUS, APB_PH_OTHER}
      apb_phase_e;
endpackage : apb_pkg

/* hdl/apb_bus_if.sv */
// Wide bus between the device end and the partner end
`timescale 1ns/1ps
interface apb_bus_if;
   import apb_pkg::*;
   logic [APB_DB_W-1:0] p_db;
   logic p_par_lo;
   logic p_par_hi;
   logic p_strobe;
   apb_phase_e phase;
   logic retry;
   logic [APB_DB_W-1:0] d_db;
   logic d_par_lo;
   logic d_par_hi;
   logic d_strobe;
   modport dev_mp (input p_db, p_par_lo, p_par_hi, p_strobe, phase, retry,
      output d_db, d_par_lo, d_par_hi, d_strobe);
   modport part_mp (output p_db, p_par_lo, p_par_hi, p_strobe, phase, retry,
      input d_db, d_par_lo, d_par_hi, d_strobe);
endinterface : apb_bus_if

/* hdl/apb_bch_enc.sv */
// Parallel check-bit generator for the (21,15,4) code
`timescale 1ns/1ps
module apb_bch_enc (
   // Information positions 14..0
   input wire logic [apb_pkg::APB_INFO_W-1:0] info_in,
   // Check bits 5..0
   output logic [apb_pkg::APB_CHK_W-1:0] chk_out
);
   import apb_pkg::*;
   for (genvar i = 0; i < APB_CHK_W; i++) begin : g_chk
      assign chk_out[i] = ^(info_in & APB_CHK_MASK[i]); // RULE1 RULE4 RULE5 RULE6 RULE7 RULE8 RULE9 RULE10
   end
endmodule : apb_bch_enc

/* hdl/apb_dev_end.sv */
// Device end: protected receive, check-byte transmit, per-nexus enable
//
// Notes on behaviour
// RULE1: Code is cyclic BCH (21,15,4).
// RULE2: Serial reference shifts bits 14..0, 15 clocks.
// RULE3: Check bits occupy positions 15 to 20.
// RULE4: Check bit 0 parity over its positions.
// RULE5: Check bit 1 parity over its positions.
// RULE6: Check bit 2 parity over its positions.
// RULE7: Check bit 3 parity over its positions.
// RULE8: Check bit 4 parity over its positions.
// RULE9: Check bit 5 parity over its positions.
// RULE10: Check bits computed in parallel, combinationally.
// RULE11: Per-nexus enable; check all protected phases.
// RULE12: Enable cleared by reset, port reset, mode change.
// RULE13: Never check information unit transfers.
// RULE14: Check byte on upper lines, same strobe.
// RULE15: Check byte sent even when checking off.
// RULE16: Enable after enough valid check words.
// RULE17: Disable on idle upper byte or errors.
// RULE18: Low parity bits 7-0, high parity 15-8.
// RULE19: Code error reported like a parity error.
// RULE20: Positions: byte, lines 8-9, zeros, sequence.
// RULE21: Sequence ID restarts each run, counts modulo four.
// RULE22: Mismatch including sequence makes transfer invalid.
// RULE23: Recompute check from latched fields, compare all.
`timescale 1ns/1ps
module apb_dev_end #(
   parameter int NEXUS_W = apb_pkg::APB_NEXUS_W,
   parameter int ENABLE_WORDS = apb_pkg::APB_ENABLE_WORDS,
   parameter int DISABLE_WORDS = apb_pkg::APB_DISABLE_WORDS
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_in,
   // Bus
   apb_bus_if.dev_mp bus,
   // Nexus and mode control
   input wire logic [NEXUS_W-1:0] nexus_in,
   input wire logic iu_mode_in,
   input wire logic port_reset_in,
   input wire logic xcvr_mode_chg_in,
   // Transmit side
   input wire logic tx_valid_in,
   input wire logic [7:0] tx_byte_in,
   output logic tx_ready_out,
   // Receive side
   output logic [7:0] rx_byte_out,
   output logic rx_valid_out,
   output logic rx_err_out,
   output logic rx_code_err_out,
   output logic chk_en_out
);
   import apb_pkg::*;

   localparam int NEXUS_N = 1 << NEXUS_W;

   // Refuse parameter values that the counters or the enable table cannot hold
   if (NEXUS_W < 1 || NEXUS_W > 8) begin : g_bad_nexus_w
      $error("NEXUS_W out of range");
   end
   if (ENABLE_WORDS < 1 || ENABLE_WORDS >= (1 << APB_CNT_W)) begin : g_bad_enable_words
      $error("ENABLE_WORDS out of range");
   end
   if (DISABLE_WORDS < 1 || DISABLE_WORDS >= (1 << APB_CNT_W)) begin : g_bad_disable_words
      $error("DISABLE_WORDS out of range");
   end

   typedef struct packed {
      logic [NEXUS_N-1:0] en;
      apb_phase_e last_phase;
      logic [NEXUS_W-1:0] last_nexus;
      logic [APB_SEQ_W-1:0] rx_seq;
      logic [APB_SEQ_W-1:0] tx_seq;
      logic [APB_CNT_W-1:0] good_cnt;
      logic [APB_CNT_W-1:0] bad_cnt;
      logic [7:0] rx_byte;
      logic rx_valid;
      logic rx_err;
      logic code_err;
      logic chk_en;
      logic [APB_DB_W-1:0] d_db;
      logic d_par_lo;
      logic d_par_hi;
      logic d_strobe;
      logic tx_ready;
   } apb_dev_state_s;

   localparam apb_dev_state_s ST_RESET = '{
      en: '0, last_phase: APB_PH_OTHER, last_nexus: '0, rx_seq: APB_SEQ_RESET,
      tx_seq: APB_SEQ_RESET, good_cnt: '0, bad_cnt: '0, rx_byte: 8'h00,
      rx_valid: 1'b0, rx_err: 1'b0, code_err: 1'b0, chk_en: 1'b0, d_db: 16'h0000,
      d_par_lo: 1'b0, d_par_hi: 1'b0, d_strobe: 1'b0, tx_ready: 1'b0};

   localparam logic [APB_CNT_W-1:0] EN_LAST = APB_CNT_W'(ENABLE_WORDS - 1);
   localparam logic [APB_CNT_W-1:0] DIS_LAST = APB_CNT_W'(DISABLE_WORDS - 1);

   apb_dev_state_s s_r;
   apb_dev_state_s s_nxt;

   logic new_run;
   logic aip;
   logic [APB_SEQ_W-1:0] rx_seq_eff;
   logic [APB_SEQ_W-1:0] tx_seq_eff;
   logic [APB_INFO_W-1:0] rx_info;
   logic [APB_INFO_W-1:0] tx_info;
   logic [APB_CHK_W-1:0] rx_chk;
   logic [APB_CHK_W-1:0] tx_chk;
   logic par_lo_ok;
   logic par_hi_ok;
   logic code_ok;
   logic upper_idle;
   logic cur_en;
   logic tx_take;

   // Sequence restarts on a phase change or a message-out retry
   assign new_run = (bus.phase != s_r.last_phase) || bus.retry; // RULE21
   assign rx_seq_eff = new_run ? APB_SEQ_RESET : s_r.rx_seq; // RULE21
   assign tx_seq_eff = new_run ? APB_SEQ_RESET : s_r.tx_seq; // RULE21
   assign aip = (bus.phase != APB_PH_OTHER) && !iu_mode_in; // RULE13

   // Latched byte, lines 8-9, three zero positions, expected sequence
   assign rx_info = {rx_seq_eff, 3'h0, bus.p_db[9:0]}; // RULE20 RULE23
   assign tx_info = {tx_seq_eff, 3'h0, 2'h0, tx_byte_in}; // RULE20

   apb_bch_enc u_rx_enc (
      .info_in(rx_info),
      .chk_out(rx_chk)
   );

   apb_bch_enc u_tx_enc (
      .info_in(tx_info),
      .chk_out(tx_chk)
   );

   // Odd parity per byte lane
   assign par_lo_ok = ^{bus.p_db[7:0], bus.p_par_lo}; // RULE18
   assign par_hi_ok = ^{bus.p_db[15:8], bus.p_par_hi}; // RULE18
   assign code_ok = (rx_chk == bus.p_db[APB_DB_W-1:APB_POS_CHK-5]) && par_hi_ok; // RULE3 RULE23
   assign upper_idle = (bus.p_db[15:8] == 8'h00) && !bus.p_par_hi; // RULE17
   assign cur_en = s_r.en[nexus_in];
   assign tx_take = tx_valid_in && s_r.tx_ready;

   always_comb begin
      s_nxt = s_r;
      s_nxt.last_phase = bus.phase;
      s_nxt.last_nexus = nexus_in;
      s_nxt.rx_valid = 1'b0;
      s_nxt.rx_err = 1'b0;
      s_nxt.code_err = 1'b0;
      s_nxt.d_strobe = 1'b0;
      s_nxt.tx_ready = !tx_take;
      if (new_run) begin
         s_nxt.rx_seq = APB_SEQ_RESET;
         s_nxt.tx_seq = APB_SEQ_RESET;
      end
      if (nexus_in != s_r.last_nexus) begin
         s_nxt.good_cnt = '0;
         s_nxt.bad_cnt = '0;
      end
      // Receive one protected word
      if (bus.p_strobe && aip) begin // RULE11 RULE13
         s_nxt.rx_seq = rx_seq_eff + APB_SEQ_W'(1); // RULE21
         s_nxt.rx_byte = bus.p_db[7:0];
         // Code error takes the parity-error path when checking is on
         s_nxt.code_err = cur_en && !code_ok; // RULE11 RULE22
         s_nxt.rx_err = !par_lo_ok || (cur_en && !code_ok); // RULE19 RULE22
         s_nxt.rx_valid = par_lo_ok && !(cur_en && !code_ok); // RULE22
         if (par_lo_ok) begin
            if (code_ok) begin
               s_nxt.bad_cnt = '0;
               if (s_r.good_cnt >= EN_LAST) begin
                  s_nxt.en[nexus_in] = 1'b1; // RULE16
               end else begin
                  s_nxt.good_cnt = s_r.good_cnt + APB_CNT_W'(1);
               end
            end else begin
               s_nxt.good_cnt = '0;
               // Idle upper lane or a persistent code error
               if (upper_idle || !code_ok) begin
                  if (s_r.bad_cnt >= DIS_LAST) begin
                     s_nxt.en[nexus_in] = 1'b0; // RULE17
                  end else begin
                     s_nxt.bad_cnt = s_r.bad_cnt + APB_CNT_W'(1);
                  end
               end
            end
         end
      end
      // Transmit: check byte always accompanies the information byte
      if (tx_take) begin
         s_nxt.tx_seq = tx_seq_eff + APB_SEQ_W'(1); // RULE21
         s_nxt.d_db = {tx_chk, 2'h0, tx_byte_in}; // RULE3 RULE14 RULE15 RULE20
         s_nxt.d_par_lo = ~^tx_byte_in; // RULE18
         s_nxt.d_par_hi = ~^{tx_chk, 2'h0}; // RULE18
         s_nxt.d_strobe = 1'b1; // RULE14
      end
      if (port_reset_in || xcvr_mode_chg_in) begin
         s_nxt.en = '0; // RULE12
         s_nxt.good_cnt = '0;
         s_nxt.bad_cnt = '0;
      end
      s_nxt.chk_en = s_nxt.en[nexus_in];
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         s_r <= ST_RESET; // RULE12
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus.d_db = s_r.d_db;
   assign bus.d_par_lo = s_r.d_par_lo;
   assign bus.d_par_hi = s_r.d_par_hi;
   assign bus.d_strobe = s_r.d_strobe;
   assign tx_ready_out = s_r.tx_ready;
   assign rx_byte_out = s_r.rx_byte;
   assign rx_valid_out = s_r.rx_valid;
   assign rx_err_out = s_r.rx_err;
   assign rx_code_err_out = s_r.code_err;
   assign chk_en_out = s_r.chk_en;
endmodule : apb_dev_end

/* hdl/apb_part_end.sv */
// Partner end: serial check generation on send, full checking on receive
`timescale 1ns/1ps
module apb_part_end (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_in,
   // Bus
   apb_bus_if.part_mp bus,
   // Phase control
   input wire apb_pkg::apb_phase_e phase_in,
   input wire logic retry_in,
   // Transmit side
   input wire logic tx_valid_in,
   input wire logic [7:0] tx_byte_in,
   output logic tx_ready_out,
   // Receive side
   output logic [7:0] rx_byte_out,
   output logic rx_valid_out,
   output logic rx_err_out
);
   import apb_pkg::*;

   typedef enum {PS_IDLE, PS_SHIFT, PS_DRIVE} apb_part_st_e;

   typedef struct packed {
      apb_part_st_e st;
      logic [APB_CHK_W-1:0] lfsr;
      logic [APB_CNT_W-1:0] cnt;
      logic [APB_INFO_W-1:0] info;
      logic [7:0] byte_q;
      logic [APB_SEQ_W-1:0] tx_seq;
      logic [APB_SEQ_W-1:0] rx_seq;
      apb_phase_e phase;
      logic retry;
      logic [APB_DB_W-1:0] p_db;
      logic p_par_lo;
      logic p_par_hi;
      logic p_strobe;
      logic tx_ready;
      logic [7:0] rx_byte;
      logic rx_valid;
      logic rx_err;
   } apb_part_state_s;

   localparam apb_part_state_s ST_RESET = '{
      st: PS_IDLE, lfsr: APB_LFSR_RESET, cnt: '0, info: '0, byte_q: 8'h00,
      tx_seq: APB_SEQ_RESET, rx_seq: APB_SEQ_RESET, phase: APB_PH_OTHER, retry: 1'b0,
      p_db: 16'h0000, p_par_lo: 1'b0, p_par_hi: 1'b0, p_strobe: 1'b0, tx_ready: 1'b0,
      rx_byte: 8'h00, rx_valid: 1'b0, rx_err: 1'b0};

   localparam logic [APB_CNT_W-1:0] SHIFT_LAST = APB_CNT_W'(APB_INFO_W - 1);

   apb_part_state_s s_r;
   apb_part_state_s s_nxt;

   logic tx_new_run;
   logic rx_new_run;
   logic [APB_SEQ_W-1:0] rx_seq_eff;
   logic [APB_INFO_W-1:0] rx_info;
   logic [APB_CHK_W-1:0] rx_chk;
   logic fb;
   logic rx_ok;

   assign tx_new_run = (phase_in != s_r.phase) || retry_in; // RULE21
   assign rx_new_run = (s_r.phase != phase_in) || s_r.retry; // RULE21
   assign rx_seq_eff = rx_new_run ? APB_SEQ_RESET : s_r.rx_seq;
   assign rx_info = {rx_seq_eff, 3'h0, bus.d_db[9:0]}; // RULE20

   apb_bch_enc u_rx_enc (
      .info_in(rx_info),
      .chk_out(rx_chk)
   );

   assign rx_ok = ^{bus.d_db[7:0], bus.d_par_lo} && ^{bus.d_db[15:8], bus.d_par_hi} &&
      (rx_chk == bus.d_db[APB_DB_W-1:APB_POS_CHK-5]); // RULE18 RULE22
   assign fb = s_r.info[APB_INFO_W-1] ^ s_r.lfsr[APB_CHK_W-1];

   always_comb begin
      s_nxt = s_r;
      s_nxt.phase = phase_in;
      s_nxt.retry = retry_in;
      s_nxt.p_strobe = 1'b0;
      s_nxt.rx_valid = 1'b0;
      s_nxt.rx_err = 1'b0;
      s_nxt.tx_ready = 1'b0;
      if (tx_new_run) begin
         s_nxt.tx_seq = APB_SEQ_RESET;
      end
      if (rx_new_run) begin
         s_nxt.rx_seq = APB_SEQ_RESET;
      end
      case (s_r.st)
         PS_IDLE: begin
            s_nxt.tx_ready = !tx_valid_in;
            if (tx_valid_in && s_r.tx_ready) begin
               s_nxt.info = {tx_new_run ? APB_SEQ_RESET : s_r.tx_seq, 3'h0, 2'h0, tx_byte_in};
               s_nxt.tx_seq = (tx_new_run ? APB_SEQ_RESET : s_r.tx_seq) + APB_SEQ_W'(1);
               s_nxt.byte_q = tx_byte_in;
               s_nxt.lfsr = APB_LFSR_RESET; // RULE2
               s_nxt.cnt = '0;
               s_nxt.st = PS_SHIFT;
            end
         end
         PS_SHIFT: begin
            // Bit 14 first; one code word bit per clock
            s_nxt.info = {s_r.info[APB_INFO_W-2:0], 1'b0}; // RULE2
            s_nxt.lfsr = {s_r.lfsr[APB_CHK_W-2:0], 1'b0} ^ (fb ? APB_GEN_TAPS : '0); // RULE1 RULE2
            s_nxt.cnt = s_r.cnt + APB_CNT_W'(1);
            if (s_r.cnt == SHIFT_LAST) begin
               s_nxt.st = PS_DRIVE;
            end
         end
         PS_DRIVE: begin
            s_nxt.p_db = {s_r.lfsr, 2'h0, s_r.byte_q}; // RULE3 RULE14 RULE15
            s_nxt.p_par_lo = ~^s_r.byte_q; // RULE18
            s_nxt.p_par_hi = ~^{s_r.lfsr, 2'h0}; // RULE18
            s_nxt.p_strobe = 1'b1; // RULE14
            s_nxt.st = PS_IDLE;
         end
         default: begin
            s_nxt.st = PS_IDLE;
         end
      endcase
      if (bus.d_strobe && phase_in != APB_PH_OTHER) begin
         s_nxt.rx_seq = rx_seq_eff + APB_SEQ_W'(1); // RULE21
         s_nxt.rx_byte = bus.d_db[7:0];
         s_nxt.rx_valid = rx_ok; // RULE22
         s_nxt.rx_err = !rx_ok;
      end
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         s_r <= ST_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus.p_db = s_r.p_db;
   assign bus.p_par_lo = s_r.p_par_lo;
   assign bus.p_par_hi = s_r.p_par_hi;
   assign bus.p_strobe = s_r.p_strobe;
   assign bus.phase = s_r.phase;
   assign bus.retry = s_r.retry;
   assign tx_ready_out = s_r.tx_ready;
   assign rx_byte_out = s_r.rx_byte;
   assign rx_valid_out = s_r.rx_valid;
   assign rx_err_out = s_r.rx_err;
endmodule : apb_part_end

/* tb/apb_bus_asserts.sv */
// Wire-level checks on the protected wide bus between the two ends
`timescale 1ns/1ps
module apb_bus_asserts (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_in,
   // Partner to device
   input wire logic [apb_pkg::APB_DB_W-1:0] p_db,
   input wire logic p_par_lo,
   input wire logic p_par_hi,
   input wire logic p_strobe,
   input wire apb_pkg::apb_phase_e phase,
   input wire logic retry,
   // Device to partner
   input wire logic [apb_pkg::APB_DB_W-1:0] d_db,
   input wire logic d_par_lo,
   input wire logic d_par_hi,
   input wire logic d_strobe
);
   import apb_pkg::*;
   logic [1:0] seq_p_r;
   logic [1:0] seq_d_r;
   apb_phase_e phase_r;
   function automatic logic [5:0] code_of(input logic [14:0] w);
      code_of = {^(w & 15'h5677), ^(w & 15'h7d4c), ^(w & 15'h3ea6),
         ^(w & 15'h1f53), ^(w & 15'h59de), ^(w & 15'h2cef)};
   endfunction : code_of
   // Expected sequence ID of each direction within the current run
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         seq_p_r <= 2'h0;
         seq_d_r <= 2'h0;
         phase_r <= APB_PH_OTHER;
      end else begin
         phase_r <= phase;
         if (phase != phase_r || retry) begin
            seq_p_r <= 2'h0;
            seq_d_r <= 2'h0;
         end else begin
            seq_p_r <= seq_p_r + {1'h0, p_strobe};
            seq_d_r <= seq_d_r + {1'h0, d_strobe};
         end
      end
   end
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);
   AST_P_CHK: assert property (
      p_strobe |-> p_db[15:10] == code_of({seq_p_r, 3'h0, p_db[9:0]}))
      else $error("partner check byte wrong");
   AST_D_CHK: assert property (
      d_strobe |-> d_db[15:10] == code_of({seq_d_r, 3'h0, d_db[9:0]}))
      else $error("device check byte wrong");
   AST_P_PAR: assert property (
      p_strobe |-> p_par_lo == ~^p_db[7:0] && p_par_hi == ~^p_db[15:8])
      else $error("partner parity wrong");
   AST_D_PAR: assert property (
      d_strobe |-> d_par_lo == ~^d_db[7:0] && d_par_hi == ~^d_db[15:8])
      else $error("device parity wrong");
   AST_P_RSVD: assert property (
      p_strobe |-> p_db[9:8] == 2'h0)
      else $error("partner reserved lines asserted");
   AST_D_RSVD: assert property (
      d_strobe |-> d_db[9:8] == 2'h0)
      else $error("device reserved lines asserted");
   AST_P_PULSE: assert property (
      p_strobe |=> !p_strobe && $stable(p_db))
      else $error("partner word not held");
   AST_D_PULSE: assert property (
      d_strobe |=> !d_strobe && $stable(d_db))
      else $error("device word not held");
endmodule : apb_bus_asserts

/* tb/test_async_phase_bch_protection.sv */
// Loopback bench joining the device end and the partner end
`timescale 1ns/1ps
module test_async_phase_bch_protection;
   import apb_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] nexus = 4'h1;
   logic iu = 1'b0;
   logic port_rst = 1'b0;
   logic mode_chg = 1'b0;
   logic d_txv = 1'b0;
   logic [7:0] d_txb = 8'h00;
   logic d_rdy, d_rxv, d_rxe, d_cerr, d_en, p_rdy, p_rxv, p_rxe;
   logic [7:0] d_rxb, p_rxb;
   apb_phase_e ph = APB_PH_COMMAND;
   logic rtry = 1'b0;
   logic p_txv = 1'b0;
   logic [7:0] p_txb = 8'h00;
   logic [31:0] lfsr = 32'ha12f5e93;
   logic [10:0] dq[$];
   logic [10:0] pq[$];
   int num_errors = 0;
   int checks = 0;
   int cycles = 0;
   apb_bus_if bus_if();
   apb_dev_end u_apb_dev_end (.ref_clk_in(clk), .reset_in(rst), .bus(bus_if.dev_mp),
      .nexus_in(nexus), .iu_mode_in(iu), .port_reset_in(port_rst),
      .xcvr_mode_chg_in(mode_chg), .tx_valid_in(d_txv), .tx_byte_in(d_txb),
      .tx_ready_out(d_rdy), .rx_byte_out(d_rxb), .rx_valid_out(d_rxv),
      .rx_err_out(d_rxe), .rx_code_err_out(d_cerr), .chk_en_out(d_en));
   apb_part_end u_apb_part_end (.ref_clk_in(clk), .reset_in(rst), .bus(bus_if.part_mp),
      .phase_in(ph), .retry_in(rtry), .tx_valid_in(p_txv), .tx_byte_in(p_txb),
      .tx_ready_out(p_rdy), .rx_byte_out(p_rxb), .rx_valid_out(p_rxv), .rx_err_out(p_rxe));
   apb_bus_asserts u_apb_bus_asserts (.ref_clk_in(clk), .reset_in(rst),
      .p_db(bus_if.p_db), .p_par_lo(bus_if.p_par_lo), .p_par_hi(bus_if.p_par_hi),
      .p_strobe(bus_if.p_strobe), .phase(bus_if.phase), .retry(bus_if.retry),
      .d_db(bus_if.d_db), .d_par_lo(bus_if.d_par_lo), .d_par_hi(bus_if.d_par_hi),
      .d_strobe(bus_if.d_strobe));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop;
      $display("checks=%0d errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next
   // Partner sends one random word; flags are {valid, err, code_err} expected at the device
   task automatic psend(input logic [2:0] flags, input logic noted);
      int n;
      n = 0;
      lfsr = lfsr_next(lfsr);
      if (noted) dq.push_back({flags, lfsr[7:0]});
      @(negedge clk);
      p_txv = 1'b1;
      p_txb = lfsr[7:0];
      while (p_rdy !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      if (n == 40) num_errors++;
      @(negedge clk);
      p_txv = 1'b0;
      repeat (20) @(negedge clk);
   endtask : psend
   task automatic dsend;
      int n;
      n = 0;
      lfsr = lfsr_next(lfsr);
      pq.push_back({3'h4, lfsr[7:0]});
      @(negedge clk);
      d_txv = 1'b1;
      d_txb = lfsr[7:0];
      while (d_rdy !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      if (n == 40) num_errors++;
      @(negedge clk);
      d_txv = 1'b0;
      repeat (4) @(negedge clk);
   endtask : dsend
   // Result watchers take the oldest note whenever a word completes
   always @(negedge clk) begin
      if ((d_rxv | d_rxe) === 1'b1)
         check({d_rxv, d_rxe, d_cerr, d_rxb}, dq.size() ? dq.pop_front() : 11'h7ff);
      if ((p_rxv | p_rxe) === 1'b1)
         check({p_rxv, p_rxe, 1'b0, p_rxb}, pq.size() ? pq.pop_front() : 11'h7ff);
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         report_and_stop();
      end
   end
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      check(d_en, 1'b0);
      for (int i = 0; i < 6; i++) begin
         psend(3'h4, 1'b1);
         if (i == 1) check(d_en, 1'b1);
      end
      nexus = 4'h2;
      @(negedge clk);
      check(d_en, 1'b0);
      repeat (5) dsend();
      nexus = 4'h1;
      @(negedge clk);
      check(d_en, 1'b1);
      // Fresh runs in the other protected phases
      ph = APB_PH_MESSAGE;
      repeat (3) @(negedge clk);
      psend(3'h4, 1'b1);
      dsend();
      ph = APB_PH_STATUS;
      repeat (3) @(negedge clk);
      psend(3'h4, 1'b1);
      // Word skipped under unit transfers desynchronises the sequence ID
      iu = 1'b1;
      psend(3'h0, 1'b0);
      iu = 1'b0;
      // The offset persists, so repeated code errors switch checking off
      repeat (4) psend(3'h3, 1'b1);
      check(d_en, 1'b0);
      psend(3'h4, 1'b1);
      rtry = 1'b1;
      @(negedge clk);
      rtry = 1'b0;
      repeat (2) @(negedge clk);
      repeat (2) psend(3'h4, 1'b1);
      check(d_en, 1'b1);
      ph = APB_PH_OTHER;
      psend(3'h0, 1'b0);
      ph = APB_PH_COMMAND;
      repeat (3) @(negedge clk);
      port_rst = 1'b1;
      @(negedge clk);
      port_rst = 1'b0;
      @(negedge clk);
      check(d_en, 1'b0);
      repeat (2) psend(3'h4, 1'b1);
      check(d_en, 1'b1);
      mode_chg = 1'b1;
      @(negedge clk);
      mode_chg = 1'b0;
      @(negedge clk);
      check(d_en, 1'b0);
      check(dq.size() + pq.size(), 0);
      report_and_stop();
   end
endmodule : test_async_phase_bch_protection
